/* File: rsc_defs.vh */
// Timing counts and field encodings for the radio state controller
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH

// ****************************************
// Transition delays in crystal cycles
// ****************************************
`define RSC_IDLE_TO_RX_CYC 24'd1953
`define RSC_IDLE_TO_TX_CYC 24'd1954
`define RSC_RX_TX_SWAP_CYC 24'd782
`define RSC_RX_TO_IDLE_CYC 24'd2
`define RSC_MANUAL_CAL_CYC 24'd283
`define RSC_SYNTH_ON_TO_TX_CYC 24'd1
`define RSC_SYNTH_CAL_CYC 18815

// ****************************************
// Wake timer and RC oscillator lock
// ****************************************
`define RSC_RC_DIVIDE 10'd750
`define RSC_RC_DIVIDE_LAST 10'd749
`define RSC_EXP_STEP 5

// ****************************************
// After-packet destination encodings
// ****************************************
`define RSC_NEXT_IDLE 2'h0
`define RSC_NEXT_SYNTH 2'h1
`define RSC_NEXT_TX 2'h2
`define RSC_NEXT_RX 2'h3

// ****************************************
// Automatic calibration policy encodings
// ****************************************
`define RSC_CAL_NEVER 2'h0
`define RSC_CAL_LEAVE_IDLE 2'h1
`define RSC_CAL_EACH_RETURN 2'h2
`define RSC_CAL_FOURTH_RETURN 2'h3
`define RSC_FOURTH_RETURN_COUNT 2'h3

`endif

/* File: rsc_radio_ctrl.v */
// Radio state controller with sleep, calibration and wake polling timer
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.vh"

module rsc_radio_ctrl #(
  parameter SYNTH_CAL_CYCLES = `RSC_SYNTH_CAL_CYC
) (
  input wire clock,
  input wire rstn,
  input wire chipSelectN,
  input wire idleStrobe,
  input wire receiveStrobe,
  input wire transmitStrobe,
  input wire synthOnStrobe,
  input wire calibrateStrobe,
  input wire powerDownStrobe,
  input wire wakePollStrobe,
  input wire [1:0] autoCalPolicy,
  input wire [1:0] afterRxState,
  input wire [1:0] afterTxState,
  input wire channelClear,
  input wire packetReceived,
  input wire packetSent,
  input wire rxTimeout,
  input wire rcOscEnable,
  input wire rcCalEnable,
  input wire [7:0] wakePeriodHigh,
  input wire [7:0] wakePeriodLow,
  input wire [1:0] wakePeriodExponent,
  input wire [7:0] wakeSettleTimeout,
  input wire [2:0] ampRampSetting,
  input wire [15:0] symbolCycles,
  output wire [2:0] radioState,
  output wire regulatorOn,
  output wire crystalOn,
  output reg synthCalActive,
  output reg fifoFlush,
  output reg wakeEvent0,
  output reg wakeEvent1,
  output wire rcCalActive,
  output reg rcLockTick
);

  // ****************************************
  // States and helpers
  // ****************************************
  localparam SLEEP = 3'd0;
  localparam IDLE = 3'd1;
  localparam RX = 3'd2;
  localparam TX = 3'd3;
  localparam SYNTH = 3'd4;
  localparam SETTLE = 3'd5;

  // Quarter symbol plus ramp share; rounded down to whole cycles
  function [23:0] txExitCycles;
    input [15:0] sym;
    input [2:0] ramp;
    reg [23:0] quarter;
    reg [23:0] rampPart;
    begin
      quarter = {10'h000, sym[15:2]};
      rampPart = ({8'h00, sym} * {21'h000000, ramp}) >> 3;
      txExitCycles = quarter + rampPart;
    end
  endfunction

  // Automatic return calibrates on every return or on every fourth
  function autoReturnCal;
    input [1:0] policy;
    input [1:0] count;
    begin
      autoReturnCal = (policy == `RSC_CAL_EACH_RETURN) ||
        ((policy == `RSC_CAL_FOURTH_RETURN) && (count == `RSC_FOURTH_RETURN_COUNT));
    end
  endfunction

  // Full wake period in 750-cycle ticks
  function [30:0] wakePeriod;
    input [15:0] mantissa;
    input [1:0] exponent;
    begin
      wakePeriod = {15'h0000, mantissa} << (`RSC_EXP_STEP * exponent);
    end
  endfunction

  reg [2:0] state;
  reg [2:0] target;
  reg [23:0] delayCount;
  reg sleepPending;
  reg wakeMode;
  reg [1:0] returnCount;
  reg csSync1;
  reg csSync2;
  reg csPrev;
  reg [9:0] rcDivider;
  reg [30:0] wakeCount;
  reg [7:0] settleCount;
  reg settleRun;

  wire csRise = csSync2 & ~csPrev;
  wire leaveCal = (autoCalPolicy == `RSC_CAL_LEAVE_IDLE);
  wire returnCal = autoReturnCal(autoCalPolicy, returnCount);
  wire [23:0] txExit = txExitCycles(symbolCycles, ampRampSetting);
  wire [23:0] calCycles = SYNTH_CAL_CYCLES[23:0];
  wire [30:0] periodTicks = wakePeriod({wakePeriodHigh, wakePeriodLow}, wakePeriodExponent);
  wire timerRun = wakeMode && ((state != SLEEP) || rcOscEnable);

  // Core supply and crystal follow the controller out of sleep
  assign radioState = state;
  assign regulatorOn = (state != SLEEP);
  assign crystalOn = (state != SLEEP);
  assign rcCalActive = rcCalEnable && (state != SLEEP);

  // Load the settle counter for a state change, optionally calibrating
  task goTo;
    input [2:0] dest;
    input [23:0] cycles;
    input withCal;
    begin
      target <= dest;
      state <= SETTLE;
      delayCount <= withCal ? (cycles + calCycles) : cycles;
      synthCalActive <= withCal;
    end
  endtask

  // ****************************************
  // Select pin synchroniser
  // ****************************************
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      csSync1 <= 1'b1;
      csSync2 <= 1'b1;
      csPrev <= 1'b1;
    end else begin
      csSync1 <= chipSelectN;
      csSync2 <= csSync1;
      csPrev <= csSync2;
    end
  end

  // ****************************************
  // Wake timer and RC lock divider
  // ****************************************
  // One tick per 750 crystal cycles stands in for the RC clock
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rcDivider <= 10'h000;
      rcLockTick <= 1'b0;
      wakeCount <= 31'h00000000;
      settleCount <= 8'h00;
      settleRun <= 1'b0;
      wakeEvent0 <= 1'b0;
      wakeEvent1 <= 1'b0;
    end else begin
      wakeEvent0 <= 1'b0;
      wakeEvent1 <= 1'b0;
      rcLockTick <= 1'b0;
      if (rcDivider == `RSC_RC_DIVIDE_LAST) begin
        rcDivider <= 10'h000;
        rcLockTick <= 1'b1;
      end else begin
        rcDivider <= rcDivider + 10'h001;
      end
      if (!timerRun) begin
        wakeCount <= 31'h00000000;
        settleRun <= 1'b0;
      end else if (rcDivider == `RSC_RC_DIVIDE_LAST) begin
        // Period in ticks reached: first event, then settle countdown
        if (wakeCount + 31'h00000001 >= periodTicks) begin
          wakeCount <= 31'h00000000;
          wakeEvent0 <= 1'b1;
          settleRun <= 1'b1;
          settleCount <= 8'h00;
        end else begin
          wakeCount <= wakeCount + 31'h00000001;
        end
        if (settleRun) begin
          if (settleCount + 8'h01 >= wakeSettleTimeout) begin
            settleRun <= 1'b0;
            wakeEvent1 <= 1'b1;
          end else begin
            settleCount <= settleCount + 8'h01;
          end
        end
      end
    end
  end

  // ****************************************
  // Main controller
  // ****************************************
  // Idle strobe outranks everything so software can always regain control
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= IDLE;
      target <= IDLE;
      delayCount <= 24'h000000;
      synthCalActive <= 1'b0;
      sleepPending <= 1'b0;
      wakeMode <= 1'b0;
      returnCount <= 2'h0;
      fifoFlush <= 1'b0;
    end else begin
      fifoFlush <= 1'b0;
      if (idleStrobe) begin
        state <= IDLE;
        wakeMode <= 1'b0;
        sleepPending <= 1'b0;
        synthCalActive <= 1'b0;
        delayCount <= 24'h000000;
      end else begin
        case (state)
          IDLE: begin
            if (sleepPending && csRise) begin
              state <= SLEEP;
              sleepPending <= 1'b0;
              fifoFlush <= 1'b1;
            end else if (powerDownStrobe) begin
              sleepPending <= 1'b1;
              wakeMode <= 1'b0;
            end else if (wakePollStrobe) begin
              sleepPending <= 1'b1;
              wakeMode <= 1'b1;
            end else if (receiveStrobe) begin
              goTo(RX, `RSC_IDLE_TO_RX_CYC, leaveCal);
            end else if (transmitStrobe) begin
              goTo(TX, `RSC_IDLE_TO_TX_CYC, leaveCal);
            end else if (synthOnStrobe) begin
              goTo(SYNTH, `RSC_IDLE_TO_TX_CYC, leaveCal);
            end else if (calibrateStrobe) begin
              goTo(IDLE, `RSC_MANUAL_CAL_CYC, 1'b1);
            end
          end
          SLEEP: begin
            if (!csSync2) begin
              state <= IDLE;
            end else if (wakeMode && wakeEvent0) begin
              goTo(RX, `RSC_IDLE_TO_RX_CYC, leaveCal);
            end
          end
          RX: begin
            // Stay in receive until packet, termination timer, or a transmit or synth strobe with a clear channel
            if (packetReceived) begin
              case (afterRxState)
                `RSC_NEXT_IDLE: begin
                  goTo(IDLE, `RSC_RX_TO_IDLE_CYC, returnCal);
                  returnCount <= returnCount + 2'h1;
                end
                `RSC_NEXT_SYNTH: goTo(SYNTH, `RSC_RX_TX_SWAP_CYC, 1'b0);
                `RSC_NEXT_TX: goTo(TX, `RSC_RX_TX_SWAP_CYC, 1'b0);
                default: state <= RX;
              endcase
            end else if (rxTimeout) begin
              if (wakeMode) begin
                state <= SLEEP;
                fifoFlush <= 1'b1;
              end else begin
                goTo(IDLE, `RSC_RX_TO_IDLE_CYC, returnCal);
                returnCount <= returnCount + 2'h1;
              end
            end else if (transmitStrobe && channelClear) begin
              goTo(TX, `RSC_RX_TX_SWAP_CYC, 1'b0);
            end else if (synthOnStrobe && channelClear) begin
              goTo(SYNTH, `RSC_RX_TX_SWAP_CYC, 1'b0);
            end
          end
          TX: begin
            if (receiveStrobe) begin
              goTo(RX, `RSC_RX_TX_SWAP_CYC + txExit, 1'b0);
            end else if (packetSent) begin
              case (afterTxState)
                `RSC_NEXT_IDLE: begin
                  goTo(IDLE, txExit, returnCal);
                  returnCount <= returnCount + 2'h1;
                end
                `RSC_NEXT_SYNTH: goTo(SYNTH, txExit, 1'b0);
                `RSC_NEXT_RX: goTo(RX, `RSC_RX_TX_SWAP_CYC + txExit, 1'b0);
                default: state <= TX;
              endcase
            end
          end
          SYNTH: begin
            if (transmitStrobe) begin
              goTo(TX, `RSC_SYNTH_ON_TO_TX_CYC, 1'b0);
            end else if (receiveStrobe) begin
              goTo(RX, `RSC_RX_TX_SWAP_CYC, 1'b0);
            end
          end
          SETTLE: begin
            // A zero count still spends one cycle here
            if (delayCount <= 24'h000001) begin
              state <= target;
              synthCalActive <= 1'b0;
              delayCount <= 24'h000000;
            end else begin
              delayCount <= delayCount - 24'h000001;
            end
          end
          default: state <= IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* File: rsc_radio_ctrl_chk.sv */
// Port checks for the radio state controller
`timescale 1ns/1ps
`default_nettype none
// ****************
// Checker
// ****************
module rsc_radio_ctrl_chk #(parameter int SYNTH_CAL_CYCLES = 18815) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic idleStrobe,
  input wire logic transmitStrobe,
  input wire logic synthOnStrobe,
  input wire logic channelClear,
  input wire logic packetReceived,
  input wire logic rxTimeout,
  input wire logic [2:0] radioState,
  input wire logic regulatorOn,
  input wire logic crystalOn,
  input wire logic synthCalActive,
  input wire logic fifoFlush
);
  logic [23:0] cnt;
  logic [2:0] org;
  logic cal;
  logic abt;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Wait length and origin; an idle strobe spoils the length
  always_ff @(posedge clock) begin
    if (radioState == 3'h5) begin
      cnt <= cnt + 24'h000001;
      cal <= cal | synthCalActive;
      abt <= abt | idleStrobe;
    end else begin
      cnt <= 24'h000000;
      org <= radioState;
      cal <= 1'b0;
      abt <= 1'b0;
    end
  end
  // Wait from f into t lasts d, plus calibration
  property settle(f, t, int d);
    radioState == t && $past(radioState) == 3'h5 && org == f && !abt
      |-> cnt == d + (cal ? SYNTH_CAL_CYCLES : 0);
  endproperty
  chk_idle_rx_time: assert property (settle(3'h1, 3'h2, 1953))
    else $error("idle to rx wait");
  chk_rx_tx_time: assert property (settle(3'h2, 3'h3, 782))
    else $error("rx to tx wait");
  chk_rx_idle_time: assert property (settle(3'h2, 3'h1, 2))
    else $error("rx to idle wait");
  chk_manual_cal: assert property (settle(3'h1, 3'h1, 283))
    else $error("manual cal wait");
  chk_core_power: assert property (
    regulatorOn == (radioState != 3'h0) && crystalOn == regulatorOn)
    else $error("core power wrong");
  chk_flush_entry: assert property ($rose(radioState == 3'h0) |-> ##[0:1] fifoFlush)
    else $error("no flush");
  chk_idle_force: assert property (
    idleStrobe |=> radioState == 3'h1)
    else $error("idle strobe lost");
  chk_cca_hold: assert property (
    radioState == 3'h2 && (transmitStrobe || synthOnStrobe) && !channelClear
    && !idleStrobe && !packetReceived && !rxTimeout |=> radioState == 3'h2)
    else $error("busy channel left");
  cover property (radioState == 3'h5 && cal);
  cover property (radioState == 3'h0 ##1 radioState == 3'h1);
  cover property (fifoFlush);
endmodule
bind rsc_radio_ctrl rsc_radio_ctrl_chk #(.SYNTH_CAL_CYCLES(SYNTH_CAL_CYCLES)) i_chk (
  .clock, .rstn, .idleStrobe, .transmitStrobe, .synthOnStrobe, .channelClear,
  .packetReceived, .rxTimeout, .radioState, .regulatorOn, .crystalOn, .synthCalActive,
  .fifoFlush);
`default_nettype wire

/* File: rsc_host_model.sv */
// Strobe source acting as the controlling microcontroller
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host
// ****************
module rsc_host_model (
  input wire logic clock,
  output logic chipSelectN = 1'b1,
  output logic rcOscEnable = 1'b0,
  output logic [6:0] strobe = 7'h00
);
  // Select frames each strobe; its rise commits a pending sleep
  task automatic pulse(input int k);
    @(negedge clock);
    chipSelectN = 1'b0;
    strobe[k] = 1'b1;
    @(negedge clock);
    strobe = 7'h00;
    chipSelectN = 1'b1;
  endtask
  // Held low past the select synchroniser
  task automatic wake();
    chipSelectN = 1'b0;
    repeat (6) @(negedge clock);
    chipSelectN = 1'b1;
    repeat (4) @(negedge clock); // Rise must clear the synchroniser before a new frame
  endtask
  // Oscillator first, as it clocks the wake timer
  task automatic poll();
    rcOscEnable = 1'b1;
    pulse(6);
  endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the radio state controller
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench
// ****************
module tb;
  localparam int CAL = 10;
  logic clock, rstn, chipSelectN, rcOscEnable, cc, prx, ptx, rto;
  logic [6:0] strobe;
  logic [1:0] pol, arx, atx;
  logic [2:0] ramp, radioState;
  logic [15:0] sym;
  logic regulatorOn, crystalOn, synthCalActive, fifoFlush, rcCalActive, we0, we1, rlt;
  // Wake timer setup: three-tick period, wake_settle_timeout two ticks after wake_period_mantissa
  logic rce = 1'b1;
  logic [7:0] wph = 8'h00;
  logic [7:0] wpl = 8'h03;
  logic [1:0] wpe = 2'h0;
  logic [7:0] wst = 8'h02;
  logic [2:0] evs;
  assign evs = {rlt, we1, we0};
  int n_fail, total_checks, seed, n, flushes;
  rsc_host_model i_host (.clock, .chipSelectN, .rcOscEnable, .strobe);
  rsc_radio_ctrl #(.SYNTH_CAL_CYCLES(CAL)) i_dut (
    .clock, .rstn, .chipSelectN, .idleStrobe(strobe[0]), .receiveStrobe(strobe[1]),
    .transmitStrobe(strobe[2]), .synthOnStrobe(strobe[3]), .calibrateStrobe(strobe[4]),
    .powerDownStrobe(strobe[5]), .wakePollStrobe(strobe[6]), .autoCalPolicy(pol),
    .afterRxState(arx), .afterTxState(atx), .channelClear(cc), .packetReceived(prx),
    .packetSent(ptx), .rxTimeout(rto), .rcOscEnable, .rcCalEnable(rce),
    .wakePeriodHigh(wph), .wakePeriodLow(wpl), .wakePeriodExponent(wpe),
    .wakeSettleTimeout(wst), .ampRampSetting(ramp), .symbolCycles(sym), .radioState,
    .regulatorOn, .crystalOn, .synthCalActive, .fifoFlush,
    .wakeEvent0(we0), .wakeEvent1(we1),
    .rcCalActive, .rcLockTick(rlt));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Flushes counted, since a pulse is easy to miss
  always @(posedge clock) flushes += int'(fifoFlush === 1'b1);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Counts wait cycles; bounded so a stuck wait cannot hang
  task automatic settle();
    for (n = 0; radioState === 3'h5 && n < 40000; n++) @(negedge clock);
  endtask
  // Cycles to the next pulse of a wake timer or RC lock output, bounded
  task automatic untilEv(input int e);
    @(negedge clock);
    for (n = 1; evs[e] !== 1'b1 && n < 5000; n++) @(negedge clock);
  endtask
  task automatic go(input int k, input logic [2:0] st, input int cyc);
    i_host.pulse(k);
    settle();
    check(n, cyc);
    check(32'(radioState), 32'(st));
  endtask
  task automatic hit(input int k);
    @(negedge clock);
    {rto, ptx, prx} = 3'b001 << k;
    @(negedge clock);
    {rto, ptx, prx} = 3'b000;
  endtask
  function automatic logic [2:0] dst(input int d);
    return d == 0 ? 3'h1 : d == 1 ? 3'h4 : d == 2 ? 3'h3 : 3'h2;
  endfunction
  function automatic int txExit(input int d);
    return d == 2 ? 0 : int'(sym) / 4 + int'(sym) * int'(ramp) / 8 + (d == 3 ? 782 : 0);
  endfunction
  task automatic results();
    if (n_fail == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Limit well above the summed waits
  initial begin
    #800000;
    n_fail++;
    results();
  end
  initial begin
    seed = 32'h004f;
    {rstn, pol, arx, atx, cc, prx, ptx, rto, ramp} = 0;
    sym = 16'h0010;
    repeat (3) @(negedge clock);
    rstn = 1'b1;
    check(32'(radioState), 1);
    check(32'(rcCalActive), 1);
    untilEv(2);
    untilEv(2);
    check(n, 750);
    go(1, 3'h2, 1953);
    repeat (20) @(negedge clock);
    check(32'(radioState), 2);
    i_host.pulse(2);
    check(32'(radioState), 2);
    cc = 1'b1;
    go(2, 3'h3, 782);
    go(1, 3'h2, 786);
    for (int d = 0; d < 4; d++) begin
      arx = 2'(d);
      hit(0);
      settle();
      check(n, d == 0 ? 2 : d == 3 ? 0 : 782);
      check(32'(radioState), 32'(dst(d)));
      i_host.pulse(0);
      settle();
      go(1, 3'h2, 1953);
    end
    // Random symbol length and ramp across every after-send choice
    for (int i = 0; i < 8; i++) begin
      atx = 2'(i);
      sym = 16'(8 + 8 * ($unsigned($random(seed)) % 8));
      ramp = 3'($random(seed));
      i_host.pulse(0);
      settle();
      go(2, 3'h3, 1954);
      hit(1);
      settle();
      check(n, txExit(i % 4));
      check(32'(radioState), 32'(dst(i % 4)));
    end
    i_host.pulse(0);
    settle();
    pol = 2'h1;
    go(1, 3'h2, 1953 + CAL);
    pol = 2'h2;
    hit(2);
    settle();
    check(n, 2 + CAL);
    go(1, 3'h2, 1953);
    i_host.pulse(0);
    check(32'(synthCalActive), 0);
    settle();
    pol = 2'h0;
    go(4, 3'h1, 283 + CAL);
    i_host.pulse(5);
    repeat (6) @(negedge clock);
    check(32'(radioState), 0);
    check(32'(rcCalActive), 0);
    check(flushes, 1);
    i_host.wake();
    check(32'(radioState), 1);
    i_host.poll();
    repeat (6) @(negedge clock);
    check(flushes, 2);
    for (n = 0; radioState !== 3'h2 && n < 5000; n++) @(negedge clock);
    check(32'(radioState), 2);
    // Timer keeps running in receive; time both events there
    untilEv(0);
    untilEv(1);
    check(n, 750 * int'(wst));
    untilEv(0);
    check(n, 750 * (int'({wph, wpl}) - int'(wst)));
    hit(2);
    repeat (4) @(negedge clock);
    check(32'(radioState), 0);
    check(flushes, 3);
    i_host.pulse(0);
    repeat (4) @(negedge clock);
    check(32'(radioState), 1);
    untilEv(0);
    check(n, 5000);
    rce = 1'b0;
    @(negedge clock);
    check(32'(rcCalActive), 0);
    results();
  end
endmodule
`default_nettype wire
